// *** src/rsx_pkg.sv ***
// Constants and types shared by the rotate and power-down execution logic.
// Assumes one core clock at 40 MHz, with one instruction cycle spanning four clocks.
package rsx_pkg;

  // Instruction word layout
  localparam int          RSX_INSTR_W       = 14;
  localparam int          RSX_OPC_HI        = 13;
  localparam int          RSX_OPC_LO        = 8;
  localparam int          RSX_DEST_BIT      = 7;
  localparam int          RSX_FADDR_W       = 7;
  localparam logic [5:0]  RSX_OPC_ROT_LEFT  = 6'h0D;
  localparam logic [5:0]  RSX_OPC_ROT_RIGHT = 6'h0C;
  localparam logic [13:0] RSX_OPC_SLEEP     = 14'h0063;

  // Register map (byte addresses)
  localparam logic [7:0]  RSX_OFS_CTRL      = 8'h00;
  localparam logic [7:0]  RSX_OFS_STATUS    = 8'h04;
  localparam int          RSX_CTRL_EN_BIT   = 0;
  localparam int          RSX_CTRL_WAKE_BIT = 1;
  localparam int          RSX_STAT_DOWN_BIT = 0;
  localparam int          RSX_STAT_TIME_BIT = 1;
  localparam int          RSX_STAT_OSC_BIT  = 2;

  // Values after reset
  localparam logic        RSX_RST_ENABLE    = 1'b1;
  localparam logic        RSX_RST_DOWN_FLAG = 1'b1;
  localparam logic        RSX_RST_TIME_FLAG = 1'b1;
  localparam logic [7:0]  RSX_WDOG_CLR_VAL  = 8'h00;

  // Quarter phases of one instruction cycle
  typedef enum logic [3:0] {
    RSX_Q1 = 4'b0001,
    RSX_Q2 = 4'b0010,
    RSX_Q3 = 4'b0100,
    RSX_Q4 = 4'b1000
  } rsx_quarter_type;

endpackage

// *** src/rsx_rot_if.sv ***
// Carrier between the execution sequencer and the rotate datapath.
// Assumes both ends share the core clock.
`timescale 1ns/100ps
interface rsx_rot_if;
  logic       load;
  logic       leftDir;
  logic [7:0] operand;
  logic       carryIn;
  logic [7:0] result;
  logic       carryOut;

  modport seq  (output load, leftDir, operand, carryIn, input result, carryOut);
  modport unit (input load, leftDir, operand, carryIn, output result, carryOut);
endinterface

// *** src/rsx_rotate_unit.sv ***
// Registered rotate-through-carry datapath.
// Assumes load is a one-cycle pulse; result holds until the next load.
`timescale 1ns/100ps
module rsx_rotate_unit
  import rsx_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  rsx_rot_if.unit   rot
);

  // Rotate one place through carry, toward MSB or LSB
  always_ff @(posedge clk) begin
    if (rst) begin
      rot.result   <= 8'h00;
      rot.carryOut <= 1'b0;
    end else if (rot.load) begin
      if (rot.leftDir) begin
        rot.result   <= {rot.operand[6:0], rot.carryIn};
        rot.carryOut <= rot.operand[7];
      end else begin
        rot.result   <= {rot.carryIn, rot.operand[7:1]};
        rot.carryOut <= rot.operand[0];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rot_left_a: assert property (rot.load && rot.leftDir |=>
      rot.result == {$past(rot.operand[6:0]), $past(rot.carryIn)}
      && rot.carryOut == $past(rot.operand[7]))
    else $error("left rotate result wrong");

  rot_right_a: assert property (rot.load && !rot.leftDir |=>
      rot.result == {$past(rot.carryIn), $past(rot.operand[7:1])}
      && rot.carryOut == $past(rot.operand[0]))
    else $error("right rotate result wrong");

endmodule

// *** src/rsx_exec.sv ***
// Execution of the two rotate-through-carry instructions and power-down.
// Assumes the core presents instr during the first quarter (quarter[0] high),
// and that fileRdData is valid in the same cycle that fileRdEn is high.
`timescale 1ns/100ps
module rsx_exec
  import rsx_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // Decoder side
  input  wire logic [RSX_INSTR_W-1:0] instr,
  output logic [3:0]                  quarter,
  // Register file
  output logic [RSX_FADDR_W-1:0]      fileAddr,
  output logic                        fileRdEn,
  input  wire logic [7:0]             fileRdData,
  output logic                        fileWrEn,
  output logic [7:0]                  fileWrData,
  // Working register
  output logic                        wWrEn,
  output logic [7:0]                  wWrData,
  // Status carry and power-down flags
  input  wire logic                   carryIn,
  output logic                        carryWrEn,
  output logic                        carryOut,
  output logic                        powerDownFlag,
  output logic                        timeOutFlag,
  // Watchdog and oscillator control
  output logic                        watchdogClear,
  output logic                        prescalerClear,
  output logic [7:0]                  watchdogLoad,
  output logic                        oscStop
);

  rsx_quarter_type state;
  rsx_rot_if       rot ();
  logic            execEnable;
  logic            opLeft;
  logic            opRight;
  logic            opSleep;
  logic            destFile;
  logic            apbWrite;
  logic            wakeReq;
  logic            decLeft;
  logic            decRight;
  logic            decSleep;
  logic [7:0]      rdSample;
  logic            cinSample;

  // Instruction decode during the first quarter
  assign decLeft  = execEnable && instr[RSX_OPC_HI:RSX_OPC_LO] == RSX_OPC_ROT_LEFT;
  assign decRight = execEnable && instr[RSX_OPC_HI:RSX_OPC_LO] == RSX_OPC_ROT_RIGHT;
  assign decSleep = execEnable && instr == RSX_OPC_SLEEP;
  assign apbWrite = psel && penable && pready && pwrite;
  assign wakeReq  = apbWrite && paddr == RSX_OFS_CTRL && pwdata[RSX_CTRL_WAKE_BIT];

  // Quarter sequencer; holds in the last quarter while the oscillator is stopped
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= RSX_Q1;
    end else begin
      unique case (state)
        RSX_Q1: state <= RSX_Q2;
        RSX_Q2: state <= RSX_Q3;
        RSX_Q3: state <= RSX_Q4;
        RSX_Q4: state <= (oscStop && !wakeReq) ? RSX_Q4 : RSX_Q1;
      endcase
    end
  end

  assign quarter = state;

  // Latch the decoded operation for the rest of the cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      opLeft   <= 1'b0;
      opRight  <= 1'b0;
      opSleep  <= 1'b0;
      destFile <= 1'b0;
      fileAddr <= '0;
    end else if (state == RSX_Q1) begin
      opLeft   <= decLeft;
      opRight  <= decRight;
      opSleep  <= decSleep;
      destFile <= instr[RSX_DEST_BIT];
      fileAddr <= instr[RSX_FADDR_W-1:0];
    end
  end

  // File read strobe stands during the second quarter
  always_ff @(posedge clk) begin
    if (rst) begin
      fileRdEn <= 1'b0;
    end else begin
      fileRdEn <= state == RSX_Q1 && (decLeft || decRight);
    end
  end

  // Operand goes to the datapath in Q2, result is ready in Q3
  assign rot.load    = state == RSX_Q2 && (opLeft || opRight);
  assign rot.leftDir = opLeft;
  assign rot.operand = fileRdData;
  assign rot.carryIn = carryIn;

  rsx_rotate_unit u_rotate (
    .clk (clk),
    .rst (rst),
    .rot (rot)
  );

  // Destination and carry written during the fourth quarter
  always_ff @(posedge clk) begin
    if (rst) begin
      fileWrEn   <= 1'b0;
      wWrEn      <= 1'b0;
      carryWrEn  <= 1'b0;
      fileWrData <= 8'h00;
      wWrData    <= 8'h00;
      carryOut   <= 1'b0;
    end else begin
      fileWrEn   <= state == RSX_Q3 && (opLeft || opRight) && destFile;
      wWrEn      <= state == RSX_Q3 && (opLeft || opRight) && !destFile;
      carryWrEn  <= state == RSX_Q3 && (opLeft || opRight);
      fileWrData <= rot.result;
      wWrData    <= rot.result;
      carryOut   <= rot.carryOut;
    end
  end

  // Status flags change once power-down is decoded
  always_ff @(posedge clk) begin
    if (rst) begin
      powerDownFlag <= RSX_RST_DOWN_FLAG;
      timeOutFlag   <= RSX_RST_TIME_FLAG;
    end else if (state == RSX_Q1 && decSleep) begin
      powerDownFlag <= 1'b0;
      timeOutFlag   <= 1'b1;
    end
  end

  // Watchdog clear pulse and oscillator stop in the fourth quarter
  always_ff @(posedge clk) begin
    if (rst) begin
      watchdogClear  <= 1'b0;
      prescalerClear <= 1'b0;
      watchdogLoad   <= RSX_WDOG_CLR_VAL;
    end else begin
      watchdogClear  <= state == RSX_Q3 && opSleep;
      prescalerClear <= state == RSX_Q3 && opSleep;
      watchdogLoad   <= RSX_WDOG_CLR_VAL;
    end
  end

  // Stop wins over a wake request in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      oscStop <= 1'b0;
    end else if (state == RSX_Q3 && opSleep) begin
      oscStop <= 1'b1;
    end else if (wakeReq) begin
      oscStop <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge clk) begin
    if (rst) begin
      execEnable <= RSX_RST_ENABLE;
    end else if (apbWrite && paddr == RSX_OFS_CTRL) begin
      execEnable <= pwdata[RSX_CTRL_EN_BIT];
    end
  end

  // APB answer: ready in the access cycle, read data from the setup cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr != RSX_OFS_CTRL && paddr != RSX_OFS_STATUS;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (paddr == RSX_OFS_CTRL) begin
          prdata[RSX_CTRL_EN_BIT] <= execEnable;
        end else if (paddr == RSX_OFS_STATUS) begin
          prdata[RSX_STAT_DOWN_BIT] <= powerDownFlag;
          prdata[RSX_STAT_TIME_BIT] <= timeOutFlag;
          prdata[RSX_STAT_OSC_BIT]  <= oscStop;
        end
      end
    end
  end

  // Helper samples for checking the rotate result
  always_ff @(posedge clk) begin
    if (rst) begin
      rdSample  <= 8'h00;
      cinSample <= 1'b0;
    end else if (rot.load) begin
      rdSample  <= fileRdData;
      cinSample <= carryIn;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence rotIssue;
    state == RSX_Q1 && (decLeft || decRight);
  endsequence

  sequence sleepIssue;
    state == RSX_Q1 && decSleep && !wakeReq;
  endsequence

  left_rotate_write_a: assert property (
      rotIssue ##0 decLeft |-> ##3 (fileWrEn || wWrEn)
      && fileWrData == {rdSample[6:0], cinSample} && carryOut == rdSample[7])
    else $error("left rotate wrote wrong value");

  right_rotate_write_a: assert property (
      rotIssue ##0 decRight |-> ##3 (fileWrEn || wWrEn)
      && wWrData == {cinSample, rdSample[7:1]} && carryOut == rdSample[0])
    else $error("right rotate wrote wrong value");

  dest_select_a: assert property (
      rotIssue ##0 instr[RSX_DEST_BIT] |-> ##3 fileWrEn && !wWrEn)
    else $error("destination bit ignored");

  sleep_flags_a: assert property (sleepIssue |=> !powerDownFlag && timeOutFlag)
    else $error("power-down flags not updated");

  watchdog_clear_a: assert property (
      sleepIssue |-> ##3 watchdogClear && prescalerClear && watchdogLoad == 8'h00)
    else $error("watchdog not cleared on power-down");

  osc_halt_a: assert property (sleepIssue |-> ##3 oscStop && state == RSX_Q4)
    else $error("oscillator not stopped");

  sleep_one_cycle_a: assert property (
      sleepIssue |-> !fileRdEn [*3] ##1 !fileWrEn && !wWrEn && !carryWrEn)
    else $error("power-down touched the datapath");

  quarter_write_a: assert property (
      (fileWrEn || wWrEn || carryWrEn) |-> state == RSX_Q4 && carryWrEn
      && $past(state, 2) == RSX_Q2)
    else $error("rotate write outside fourth quarter");

  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("APB answer not one cycle");

endmodule

// *** verif/tb.sv ***
// Self-checking bench for the rotate and power-down execution block.
// Drives APB, instruction, register-file and carry inputs itself; one clock.
`timescale 1ns/100ps
module tb;
  import rsx_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, carryIn, carryWrEn;
  logic        carryOut, fileRdEn, fileWrEn, wWrEn, powerDownFlag, timeOutFlag;
  logic        watchdogClear, prescalerClear, oscStop, err, expPowerDown;
  logic [7:0]  paddr, fileRdData, fileWrData, wWrData, watchdogLoad;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] instr;
  logic [6:0]  fileAddr;
  logic [3:0]  quarter;
  int          fails, samples_checked;

  rsx_exec dut (
    .clk            (clk),
    .rst            (rst),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .pready         (pready),
    .prdata         (prdata),
    .pslverr        (pslverr),
    .instr          (instr),
    .quarter        (quarter),
    .fileAddr       (fileAddr),
    .fileRdEn       (fileRdEn),
    .fileRdData     (fileRdData),
    .fileWrEn       (fileWrEn),
    .fileWrData     (fileWrData),
    .wWrEn          (wWrEn),
    .wWrData        (wWrData),
    .carryIn        (carryIn),
    .carryWrEn      (carryWrEn),
    .carryOut       (carryOut),
    .powerDownFlag  (powerDownFlag),
    .timeOutFlag    (timeOutFlag),
    .watchdogClear  (watchdogClear),
    .prescalerClear (prescalerClear),
    .watchdogLoad   (watchdogLoad),
    .oscStop        (oscStop)
  );

  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checked=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bounded wait for the decode quarter
  task automatic wait_q1;
    int n;
    n = 0;
    while (quarter !== 4'b0001) begin
      @(negedge clk);
      n++;
      if (n > 40) begin
        fails++;
        tally_and_finish();
      end
    end
  endtask

  // One APB transfer; holds the request until pready is sampled at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        fails++;
        tally_and_finish();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One instruction cycle, every strobe judged against its expected quarter
  task automatic exec(input logic [13:0] ins, input logic [7:0] fd, input logic ci,
                      input logic en);
    logic       l, r, s, rot, co;
    logic [7:0] res;
    l = en && ins[13:8] == RSX_OPC_ROT_LEFT;
    r = en && ins[13:8] == RSX_OPC_ROT_RIGHT;
    s = en && ins == RSX_OPC_SLEEP;
    rot = l | r;
    res = l ? {fd[6:0], ci} : {ci, fd[7:1]};
    co = l ? fd[7] : fd[0];
    if (s)
      expPowerDown = 1'b0;
    @(posedge clk);
    instr <= ins;
    fileRdData <= fd;
    carryIn <= ci;
    @(negedge clk);
    wait_q1();
    @(posedge clk);
    instr <= 14'h0000;
    @(negedge clk);
    check(fileRdEn, rot);
    if (rot)
      check(fileAddr, ins[6:0]);
    check({powerDownFlag, timeOutFlag}, {expPowerDown, 1'b1});
    @(negedge clk);
    check({fileWrEn, wWrEn, carryWrEn}, 3'b000);
    @(negedge clk);
    check({fileWrEn, wWrEn, carryWrEn}, {rot & ins[7], rot & !ins[7], rot});
    if (rot)
      check({carryOut, ins[7] ? fileWrData : wWrData}, {co, res});
    check({watchdogClear, prescalerClear, watchdogLoad}, {s, s, 8'h00});
    check(oscStop, s);
  endtask

  // Rotates both ways, both destinations, back to back, edge addresses
  task automatic t_rotate;
    exec({RSX_OPC_ROT_LEFT, 1'b0, 7'h7F}, 8'hE6, 1'b0, 1'b1);
    exec({RSX_OPC_ROT_RIGHT, 1'b1, 7'h00}, 8'hE6, 1'b1, 1'b1);
    exec({RSX_OPC_ROT_LEFT, 1'b1, 7'h15}, 8'h80, 1'b1, 1'b1);
    exec({RSX_OPC_ROT_RIGHT, 1'b0, 7'h2A}, 8'h01, 1'b0, 1'b1);
    $display("test rotate done");
  endtask

  // Near-miss opcodes must do nothing
  task automatic t_opcodes;
    logic [13:0] tbl [3] = '{14'h0062, 14'h0064, 14'h2063};
    foreach (tbl[i])
      exec(tbl[i], 8'h5A, 1'b1, 1'b1);
    $display("test opcodes done");
  endtask

  // Execute disabled, then register map and an unmapped access
  task automatic t_regs;
    apb(1'b1, RSX_OFS_CTRL, 32'h0000_0000);
    exec({RSX_OPC_ROT_LEFT, 1'b0, 7'h01}, 8'hFF, 1'b1, 1'b0);
    exec(RSX_OPC_SLEEP, 8'h00, 1'b0, 1'b0);
    apb(1'b1, RSX_OFS_CTRL, 32'h0000_0001);
    apb(1'b0, RSX_OFS_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    apb(1'b0, 8'h08, 32'h0000_0000);
    check({err, rd[30:0]}, 32'h8000_0000);
    $display("test regs done");
  endtask

  // Power-down, stopped phase, status readback and wake
  task automatic t_sleep;
    exec(RSX_OPC_SLEEP, 8'h00, 1'b0, 1'b1);
    repeat (6) @(negedge clk);
    check(quarter, 4'b1000);
    apb(1'b0, RSX_OFS_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0006);
    apb(1'b1, RSX_OFS_CTRL, 32'h0000_0003);
    @(negedge clk);
    check({oscStop, quarter}, 5'b0_0001);
    exec({RSX_OPC_ROT_LEFT, 1'b0, 7'h03}, 8'h01, 1'b0, 1'b1);
    $display("test sleep done");
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    instr = 14'h0000;
    fileRdData = 8'h00;
    carryIn = 1'b0;
    fails = 0;
    samples_checked = 0;
    expPowerDown = 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check({quarter, powerDownFlag, timeOutFlag, oscStop}, 7'b0001_110);
    @(posedge clk);
    rst <= 1'b0;
    $display("test reset done");
    t_rotate();
    t_opcodes();
    t_regs();
    t_sleep();
    tally_and_finish();
  end
endmodule
